/* File: acs_clk_div.sv */
// Converter clock enable divider
`timescale 1ns/10ps
`default_nettype none
module acs_clk_div (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [2:0] div,
  output logic            tick
);
  logic [7:0] cnt;
  logic [7:0] mask;
  logic [7:0] gap;
  logic       primed;

  assign mask = (8'h01 << div) - 8'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt  <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt  <= cnt + 8'h01;
      tick <= ((cnt & mask) == mask);
    end
  end

  // Cycles since last tick, for checking
  always_ff @(posedge aclk) begin
    if (!aresetn || div != $past(div)) begin
      gap    <= 8'h01;
      primed <= 1'b0;
    end else if (tick) begin
      gap    <= 8'h01;
      primed <= 1'b1;
    end else begin
      gap    <= gap + 8'h01;
    end
  end

  property p_div_period;
    @(posedge aclk) disable iff (!aresetn)
    (tick && primed && $stable(div)) |-> (gap == (8'h01 << div));
  endproperty
  a_div_period: assert property (p_div_period) else $error("divider period wrong");
endmodule : acs_clk_div
`default_nettype wire

/* File: acs_core_model.sv */
// Behavioural multiplexer and converter core
`timescale 1ns/10ps
`default_nettype none
module acs_core_model (
  input  wire logic       aclk,
  input  wire logic       core_sample,
  input  wire logic       core_convert,
  input  wire logic [7:0] mux_ext_sel,
  input  wire logic       mux_bandgap_sel,
  input  wire logic       mux_ocp_sel,
  input  wire logic       mux_ground_sel,
  output logic [11:0]     core_result
);
  logic [11:0] held;
  initial core_result = 12'h000;
  always @(posedge aclk) begin
    if (core_sample)
      held <= mux_bandgap_sel ? 12'hFFF : mux_ocp_sel ? 12'h800 : mux_ground_sel ? 12'h000 : {mux_ext_sel, 4'h6};
    core_result <= core_convert ? held : ~core_result;
  end
endmodule : acs_core_model
`default_nettype wire

/* File: acs_pkg.sv */
// Constants and types for the converter input select and conversion control block
`default_nettype none
package acs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL0  = 8'h00;
  localparam logic [7:0] OFF_CTRL1  = 8'h04;
  localparam logic [7:0] OFF_RESH   = 8'h08;
  localparam logic [7:0] OFF_RESL   = 8'h0C;
  localparam logic [7:0] OFF_PINSEL = 8'h10;
  localparam logic [7:0] OFF_PORT   = 8'h14;
  localparam logic [7:0] OFF_INTC   = 8'h18;
  // converter_control_0 fields
  localparam int C0_CS_LSB = 0;
  localparam int C0_FMT    = 4;
  localparam int C0_EN     = 5;
  localparam int C0_BUSY   = 6;
  localparam int C0_START  = 7;
  // converter_control_1 fields
  localparam int C1_DIV_LSB = 0;
  localparam int C1_VRS_LSB = 3;
  localparam int C1_INS_LSB = 5;
  // Interrupt control fields
  localparam int INT_GIE  = 0;
  localparam int INT_AIE  = 1;
  localparam int INT_FLAG = 2;
  // Port control fields
  localparam int PORT_PU_LSB  = 0;
  localparam int PORT_DIR_LSB = 8;
  // Sizes
  localparam int NUM_CH = 8;
  localparam int RES_W  = 12;
  // Field codes
  localparam logic [1:0] PIN_ANALOG  = 2'h3;
  localparam logic [2:0] SRC_BANDGAP = 3'h1;
  localparam logic [2:0] SRC_OCP     = 3'h2;
  localparam logic [2:0] SRC_GND_A   = 3'h3;
  localparam logic [2:0] SRC_GND_B   = 3'h4;
  localparam logic [1:0] VRS_SUPPLY  = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Reset values
  localparam logic [3:0]  RST_CS     = 4'h0;
  localparam logic [2:0]  RST_DIV    = 3'h0;
  localparam logic [1:0]  RST_VRS    = 2'h0;
  localparam logic [2:0]  RST_INS    = 3'h0;
  localparam logic [15:0] RST_PINSEL = 16'h0000;
  localparam logic [7:0]  RST_PU     = 8'h00;
  localparam logic [7:0]  RST_DIR    = 8'hFF;
  // Conversion timing in converter clocks
  localparam int         SAMPLE_TICKS  = 4;
  localparam int         CONVERT_TICKS = 12;
  localparam int         TOTAL_TICKS   = SAMPLE_TICKS + CONVERT_TICKS;
  localparam logic [3:0] SAMPLE_LAST   = 4'(SAMPLE_TICKS - 1);
  localparam logic [3:0] CONVERT_LAST  = 4'(CONVERT_TICKS - 1);
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT} acs_seq_state_t;
endpackage : acs_pkg
`default_nettype wire

/* File: acs_seq.sv */
// Sample and convert sequencer
`timescale 1ns/10ps
`default_nettype none
module acs_seq (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic tick,
  input  wire logic launch,
  input  wire logic abort,
  output logic      sampling,
  output logic      converting,
  output logic      busy,
  output logic      done
);
  acs_pkg::acs_seq_state_t state;
  acs_pkg::acs_seq_state_t next_state;
  logic [3:0]              cnt;
  logic [3:0]              next_cnt;
  logic [4:0]              ticks_seen;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    if (abort) begin
      next_state = acs_pkg::SEQ_IDLE;
    end else if (launch) begin
      next_state = acs_pkg::SEQ_SAMPLE;
      next_cnt   = 4'h0;
    end else if (tick) begin
      case (state)
        acs_pkg::SEQ_SAMPLE: begin
          next_cnt = cnt + 4'h1;
          if (cnt == acs_pkg::SAMPLE_LAST) begin
            next_state = acs_pkg::SEQ_CONVERT;
            next_cnt   = 4'h0;
          end
        end
        acs_pkg::SEQ_CONVERT: begin
          next_cnt = cnt + 4'h1;
          if (cnt == acs_pkg::CONVERT_LAST) begin
            next_state = acs_pkg::SEQ_IDLE;
          end
        end
        default: next_state = acs_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state      <= acs_pkg::SEQ_IDLE;
      cnt        <= 4'h0;
      sampling   <= 1'b0;
      converting <= 1'b0;
      busy       <= 1'b0;
      done       <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      sampling   <= next_state == acs_pkg::SEQ_SAMPLE;
      converting <= next_state == acs_pkg::SEQ_CONVERT;
      busy       <= next_state != acs_pkg::SEQ_IDLE;
      done       <= state == acs_pkg::SEQ_CONVERT && next_state == acs_pkg::SEQ_IDLE && !abort;
    end
  end

  // Converter clocks consumed by the running conversion
  always_ff @(posedge aclk) begin
    if (!aresetn || launch) begin
      ticks_seen <= 5'h00;
    end else if (tick && state != acs_pkg::SEQ_IDLE && !abort) begin
      ticks_seen <= ticks_seen + 5'h01;
    end
  end

  property p_seq_len;
    @(posedge aclk) disable iff (!aresetn)
    done |-> (ticks_seen == 5'(acs_pkg::TOTAL_TICKS));
  endproperty
  a_seq_len: assert property (p_seq_len) else $error("conversion length wrong");
endmodule : acs_seq
`default_nettype wire

/* File: acs_top.sv */
// Converter input select, pin handover and conversion control with AXI4-Lite registers
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module acs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [11:0] core_result,
  output logic [7:0]       pin_analog_en,
  output logic [7:0]       pin_digital_en,
  output logic [7:0]       pin_pullup_en,
  output logic [7:0]       pin_input_mode,
  output logic [7:0]       mux_ext_sel,
  output logic             mux_bandgap_sel,
  output logic             mux_ocp_sel,
  output logic             mux_ground_sel,
  output logic             ref_supply_sel,
  output logic             adc_power_en,
  output logic             adc_clk_tick,
  output logic             core_sample,
  output logic             core_convert,
  output logic             irq
);
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        do_write;
  logic        wr_hit;
  logic        next_rd_hit;
  logic [31:0] next_rdata;
  logic [3:0]  channel_select;
  logic        result_format_select;
  logic        converter_enable;
  logic        start;
  logic        start_q;
  logic [2:0]  converter_clock_divider;
  logic [1:0]  reference_select;
  logic [2:0]  internal_source_select;
  logic [15:0] pin_function_select;
  logic [7:0]  pullup_req;
  logic [7:0]  port_dir_in;
  logic        global_interrupt_enable;
  logic        converter_interrupt_enable;
  logic        converter_interrupt_request;
  logic [11:0] result;
  logic [7:0]  result_high_byte;
  logic [7:0]  result_low_byte;
  logic [7:0]  analog_pin;
  logic        start_rise;
  logic        start_fall;
  logic        launch;
  logic        abort;
  logic        conversion_busy_flag;
  logic        conv_done;
  logic        flag_clear;

  // Write address and data channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      awaddr_q      <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awaddr_q      <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wdata_q      <= s_axi_wdata;
      wstrb_q      <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_comb begin
    if (awaddr_q == acs_pkg::OFF_CTRL0 || awaddr_q == acs_pkg::OFF_CTRL1) begin
      wr_hit = 1'b1;
    end else if (awaddr_q == acs_pkg::OFF_RESH || awaddr_q == acs_pkg::OFF_RESL) begin
      wr_hit = 1'b1;
    end else if (awaddr_q == acs_pkg::OFF_PINSEL || awaddr_q == acs_pkg::OFF_PORT) begin
      wr_hit = 1'b1;
    end else if (awaddr_q == acs_pkg::OFF_INTC) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= acs_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_select          <= acs_pkg::RST_CS;
      result_format_select    <= 1'b0;
      converter_enable        <= 1'b0;
      start                   <= 1'b0;
      converter_clock_divider <= acs_pkg::RST_DIV;
      reference_select        <= acs_pkg::RST_VRS;
      internal_source_select  <= acs_pkg::RST_INS;
      pin_function_select     <= acs_pkg::RST_PINSEL;
      pullup_req              <= acs_pkg::RST_PU;
      port_dir_in             <= acs_pkg::RST_DIR;
      global_interrupt_enable <= 1'b0;
      converter_interrupt_enable <= 1'b0;
    end else if (do_write) begin
      if (awaddr_q == acs_pkg::OFF_CTRL0 && wstrb_q[0]) begin
        channel_select       <= wdata_q[acs_pkg::C0_CS_LSB +: 4];
        result_format_select <= wdata_q[acs_pkg::C0_FMT];
        converter_enable     <= wdata_q[acs_pkg::C0_EN];
        start                <= wdata_q[acs_pkg::C0_START];
      end else if (awaddr_q == acs_pkg::OFF_CTRL1 && wstrb_q[0]) begin
        converter_clock_divider <= wdata_q[acs_pkg::C1_DIV_LSB +: 3];
        reference_select        <= wdata_q[acs_pkg::C1_VRS_LSB +: 2];
        internal_source_select  <= wdata_q[acs_pkg::C1_INS_LSB +: 3];
      end else if (awaddr_q == acs_pkg::OFF_PINSEL) begin
        if (wstrb_q[0]) pin_function_select[7:0] <= wdata_q[7:0];
        if (wstrb_q[1]) pin_function_select[15:8] <= wdata_q[15:8];
      end else if (awaddr_q == acs_pkg::OFF_PORT) begin
        if (wstrb_q[0]) pullup_req <= wdata_q[acs_pkg::PORT_PU_LSB +: 8];
        if (wstrb_q[1]) port_dir_in <= wdata_q[acs_pkg::PORT_DIR_LSB +: 8];
      end else if (awaddr_q == acs_pkg::OFF_INTC && wstrb_q[0]) begin
        global_interrupt_enable    <= wdata_q[acs_pkg::INT_GIE];
        converter_interrupt_enable <= wdata_q[acs_pkg::INT_AIE];
      end
    end
  end

  // Read channel
  always_comb begin
    next_rdata  = 32'h0000_0000;
    next_rd_hit = 1'b1;
    if (s_axi_araddr == acs_pkg::OFF_CTRL0) begin
      next_rdata[7:0] = {start, conversion_busy_flag, converter_enable, result_format_select, channel_select};
    end else if (s_axi_araddr == acs_pkg::OFF_CTRL1) begin
      next_rdata[7:0] = {internal_source_select, reference_select, converter_clock_divider};
    end else if (s_axi_araddr == acs_pkg::OFF_RESH) begin
      next_rdata[7:0] = result_high_byte;
    end else if (s_axi_araddr == acs_pkg::OFF_RESL) begin
      next_rdata[7:0] = result_low_byte;
    end else if (s_axi_araddr == acs_pkg::OFF_PINSEL) begin
      next_rdata[15:0] = pin_function_select;
    end else if (s_axi_araddr == acs_pkg::OFF_PORT) begin
      next_rdata[15:0] = {port_dir_in, pullup_req};
    end else if (s_axi_araddr == acs_pkg::OFF_INTC) begin
      next_rdata[2:0] = {converter_interrupt_request, converter_interrupt_enable, global_interrupt_enable};
    end else begin
      next_rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= acs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rd_hit ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Result alignment
  always_comb begin
    if (result_format_select) begin
      result_high_byte = {4'h0, result[11:8]};
      result_low_byte  = result[7:0];
    end else begin
      result_high_byte = result[11:4];
      result_low_byte  = {result[3:0], 4'h0};
    end
  end

  // Pin handover
  genvar gi;
  generate
    for (gi = 0; gi < acs_pkg::NUM_CH; gi++) begin : g_pin
      assign analog_pin[gi] = pin_function_select[2*gi +: 2] == acs_pkg::PIN_ANALOG;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pin_analog_en[gi]  <= 1'b0;
          pin_digital_en[gi] <= 1'b1;
          pin_pullup_en[gi]  <= 1'b0;
          pin_input_mode[gi] <= 1'b1;
          mux_ext_sel[gi]    <= 1'b0;
        end else begin
          pin_analog_en[gi]  <= analog_pin[gi];
          pin_digital_en[gi] <= !analog_pin[gi];
          pin_pullup_en[gi]  <= pullup_req[gi] && !analog_pin[gi];
          pin_input_mode[gi] <= port_dir_in[gi] || analog_pin[gi];
          mux_ext_sel[gi]    <= !channel_select[3] && channel_select[2:0] == 3'(gi);
        end
      end
    end
  endgenerate

  // Internal source routing and reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mux_bandgap_sel <= 1'b0;
      mux_ocp_sel     <= 1'b0;
      mux_ground_sel  <= 1'b0;
      ref_supply_sel  <= 1'b0;
      adc_power_en    <= 1'b0;
    end else begin
      mux_bandgap_sel <= internal_source_select == acs_pkg::SRC_BANDGAP;
      mux_ocp_sel     <= internal_source_select == acs_pkg::SRC_OCP;
      mux_ground_sel  <= internal_source_select == acs_pkg::SRC_GND_A
                      || internal_source_select == acs_pkg::SRC_GND_B;
      ref_supply_sel  <= reference_select == acs_pkg::VRS_SUPPLY;
      adc_power_en    <= converter_enable;
    end
  end

  // Start pulse edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start;
    end
  end

  assign start_rise = start && !start_q;
  assign start_fall = !start && start_q;
  assign launch     = start_fall && converter_enable;
  assign abort      = start_rise || !converter_enable;

  acs_clk_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .div     (converter_clock_divider),
    .tick    (adc_clk_tick)
  );

  acs_seq u_seq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .tick       (adc_clk_tick),
    .launch     (launch),
    .abort      (abort),
    .sampling   (core_sample),
    .converting (core_convert),
    .busy       (conversion_busy_flag),
    .done       (conv_done)
  );

  // Result capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= 12'h000;
    end else if (conv_done) begin
      result <= core_result;
    end
  end

  // Completion flag and interrupt
  assign flag_clear = do_write && awaddr_q == acs_pkg::OFF_INTC && wstrb_q[0] && !wdata_q[acs_pkg::INT_FLAG];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_interrupt_request <= 1'b0;
      irq                         <= 1'b0;
    end else begin
      if (conv_done) begin
        converter_interrupt_request <= 1'b1;
      end else if (flag_clear) begin
        converter_interrupt_request <= 1'b0;
      end
      irq <= converter_interrupt_request && global_interrupt_enable && converter_interrupt_enable;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_pin_exclusive;
    (pin_analog_en & (pin_digital_en | pin_pullup_en | ~pin_input_mode)) == 8'h00;
  endproperty
  a_pin_exclusive: assert property (p_pin_exclusive) else $error("analog pin keeps other function");

  property p_pin_follow;
    1'b1 |=> pin_analog_en == $past(analog_pin);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("analog pin select not applied");

  property p_ext_route;
    !channel_select[3] |=> mux_ext_sel == (8'h01 << $past(channel_select[2:0]));
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("external channel routing wrong");

  property p_ext_float;
    channel_select[3] |=> mux_ext_sel == 8'h00;
  endproperty
  a_ext_float: assert property (p_ext_float) else $error("absent channel not floating");

  property p_internal;
    internal_source_select == acs_pkg::SRC_BANDGAP |=> mux_bandgap_sel && !mux_ocp_sel && !mux_ground_sel;
  endproperty
  a_internal: assert property (p_internal) else $error("bandgap routing wrong");

  property p_ground;
    (internal_source_select == acs_pkg::SRC_GND_A || internal_source_select == acs_pkg::SRC_GND_B)
      |=> mux_ground_sel && !mux_bandgap_sel && !mux_ocp_sel;
  endproperty
  a_ground: assert property (p_ground) else $error("reserved source not grounded");

  property p_launch;
    launch |=> conversion_busy_flag && core_sample;
  endproperty
  a_launch: assert property (p_launch) else $error("start pulse did not launch");

  property p_abort;
    start_rise |=> !conversion_busy_flag;
  endproperty
  a_abort: assert property (p_abort) else $error("start rise did not reset");

  property p_done;
    conv_done |-> !conversion_busy_flag ##1 (result == $past(core_result) && converter_interrupt_request);
  endproperty
  a_done: assert property (p_done) else $error("completion handling wrong");

  property p_power;
    !converter_enable |=> !adc_power_en && !conversion_busy_flag;
  endproperty
  a_power: assert property (p_power) else $error("power down not honoured");

  property p_ref;
    reference_select == acs_pkg::VRS_SUPPLY |=> ref_supply_sel;
  endproperty
  a_ref: assert property (p_ref) else $error("reference select wrong");

  property p_format;
    result_format_select |-> result_high_byte[7:4] == 4'h0 && result_low_byte == result[7:0];
  endproperty
  a_format: assert property (p_format) else $error("right alignment wrong");

  c_launch: cover property (launch);
  c_done: cover property (conv_done);
  c_irq: cover property ($rose(irq));
  c_abort: cover property (start_rise && conversion_busy_flag);
endmodule : acs_top
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, adc_power_en;
  logic        mux_bandgap_sel, mux_ocp_sel, mux_ground_sel, ref_supply_sel, adc_clk_tick, core_sample;
  logic        core_convert;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, pin_analog_en, pin_digital_en, pin_pullup_en, pin_input_mode;
  logic [7:0]  mux_ext_sel;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [11:0] core_result;
  int          n_fail, checks, ns, nc;
  acs_top acs_top_i (.*);
  acs_core_model acs_core_model_i (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(negedge aclk) begin
    if (adc_clk_tick && core_sample) ns++;
    if (adc_clk_tick && core_convert) nc++;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    repeat (2) @(negedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rd
  task automatic t_pins;
    chk(pin_input_mode, 8'hFF);
    rd(8'h1C);
    chk(rsp, acs_pkg::RESP_SLVERR);
    wr(8'h14, 32'h00FF);
    chk(rsp, acs_pkg::RESP_OKAY);
    wr(8'h1C, 32'h0001);
    chk(rsp, acs_pkg::RESP_SLVERR);
    wr(8'h10, 32'h000C);
    chk(pin_analog_en, 8'h02);
    chk(pin_digital_en, 8'hFD);
    chk(pin_pullup_en, 8'hFD);
    chk(pin_input_mode, 8'h02);
    $display("pins done");
  endtask : t_pins
  task automatic t_mux;
    for (int c = 0; c < 9; c++) begin
      wr(8'h00, c);
      chk(mux_ext_sel, (c < 8) ? 8'(1 << c) : 8'h00);
    end
    for (int i = 1; i < 5; i++) begin
      wr(8'h04, i << 5);
      chk({mux_bandgap_sel, mux_ocp_sel, mux_ground_sel}, {i == 1, i == 2, i > 2});
    end
    wr(8'h04, 32'h00A0);
    wr(8'h00, 32'h0002);
    chk(mux_ext_sel, 8'h04);
    for (int v = 0; v < 4; v++) begin
      wr(8'h04, v << 3);
      chk(ref_supply_sel, v == 1);
    end
    $display("mux done");
  endtask : t_mux
  task automatic t_div;
    int n;
    for (int v = 0; v < 8; v += 7) begin
      wr(8'h04, v);
      repeat (2) @(negedge aclk iff adc_clk_tick);
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (!adc_clk_tick);
      chk(n, 1 << v);
    end
    $display("divider done");
  endtask : t_div
  task automatic t_conv(input logic f, input logic [3:0] cs, input logic [2:0] ins, input logic [11:0] r);
    wr(8'h18, 32'h3);
    wr(8'h00, {3'b101, f, cs});
    wr(8'h04, {ins, 5'h01});
    chk(adc_power_en, 1'b1);
    ns = 0;
    nc = 0;
    wr(8'h00, {3'b001, f, cs});
    rd(8'h00);
    chk(d[6], 1'b1);
    for (int k = 0; k < 200 && irq !== 1'b1; k++) @(negedge aclk);
    chk(irq, 1'b1);
    chk(ns, 4);
    chk(nc, 12);
    rd(8'h00);
    chk(d[6], 1'b0);
    rd(8'h08);
    chk(rsp, acs_pkg::RESP_OKAY);
    chk(d, f ? {28'h0, r[11:8]} : {24'h0, r[11:4]});
    rd(8'h0C);
    chk(d, f ? {24'h0, r[7:0]} : {24'h0, r[3:0], 4'h0});
    rd(8'h18);
    chk(d[2], 1'b1);
    wr(8'h18, 32'h3);
    chk(irq, 1'b0);
    $display("conversion done");
  endtask : t_conv
  task automatic t_abort;
    wr(8'h00, 32'h0000_00A3);
    wr(8'h00, 32'h0000_0023);
    wr(8'h00, 32'h0000_00A3);
    rd(8'h00);
    chk(d[6], 1'b0);
    wr(8'h00, 32'h0000_0023);
    rd(8'h00);
    chk(d[6], 1'b1);
    wr(8'h00, 32'h0000_0003);
    repeat (100) @(negedge aclk);
    rd(8'h18);
    chk(d[2], 1'b0);
    chk(irq, 1'b0);
    $display("abort done");
  endtask : t_abort
  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_pins;
    t_mux;
    t_div;
    t_conv(1'b0, 4'h3, 3'h0, 12'h086);
    t_conv(1'b1, 4'h8, 3'h1, 12'hFFF);
    t_abort;
    wr(8'h00, 32'h0);
    chk(adc_power_en, 1'b0);
    complete_run;
  end
  initial begin
    #1000000;
    n_fail++;
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
